/* File: src/lcscb_bridge.sv */
// Line card serial control bridge: host byte port to shared slave serial port.
// Assumes host strobes are asynchronous and held well beyond a 2 MHz period.
`timescale 1ns/1ps
module lcscb_bridge (
  // Clock and reset
  input  wire logic                         CORE_CLK_I,
  input  wire logic                         RESET_I,
  // Host byte port
  input  wire logic                         WR_N_I,
  input  wire logic                         RD_N_I,
  input  wire logic                         IF_SELECT_N_I,
  input  wire logic                         BYTE_KIND_SELECT_I,
  input  wire logic [lcscb_pkg::BYTE_W-1:0] HOST_DATA_BUS_I,
  output logic      [lcscb_pkg::BYTE_W-1:0] HOST_DATA_BUS_O,
  output logic                              HOST_DATA_BUS_OE_O,
  // Mode
  input  wire logic                         ADDRESSING_MODE_N_I,
  // Slave serial port
  input  wire logic                         SERIAL_CONTROL_LINE_I,
  output logic                              SERIAL_CONTROL_LINE_O,
  output logic                              SERIAL_CONTROL_LINE_OE_O,
  output logic                              TARGET_SELECT_PULSE_N_O,
  output logic                              SERIAL_CONTROL_CLOCK_O,
  output logic      [lcscb_pkg::BYTE_W-1:0] TARGET_ADDRESS_OUTPUTS_O
);
  import lcscb_pkg::*;

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  lcscb_host_s  host_meta_ff;
  lcscb_host_s  host_ff;
  logic         ser_meta_ff;
  logic         ser_sync_ff;
  logic         mode_meta_ff;
  logic         mode_sync_ff;

  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      host_meta_ff <= '{wr_n: 1'b1, rd_n: 1'b1, sel_n: 1'b1, kind: 1'b0, data: 8'h00};
      host_ff      <= '{wr_n: 1'b1, rd_n: 1'b1, sel_n: 1'b1, kind: 1'b0, data: 8'h00};
      ser_meta_ff  <= 1'b1;
      ser_sync_ff  <= 1'b1;
      mode_meta_ff <= 1'b1;
      mode_sync_ff <= 1'b1;
    end else begin
      host_meta_ff <= '{wr_n: WR_N_I, rd_n: RD_N_I, sel_n: IF_SELECT_N_I,
                        kind: BYTE_KIND_SELECT_I, data: HOST_DATA_BUS_I};
      host_ff      <= host_meta_ff;
      ser_meta_ff  <= SERIAL_CONTROL_LINE_I;
      ser_sync_ff  <= ser_meta_ff;
      // Mode is a strap pin; a change takes three cycles to reach the outputs
      mode_meta_ff <= ADDRESSING_MODE_N_I;
      mode_sync_ff <= mode_meta_ff;
    end
  end

  // ----------------------------------------------------------------
  // 2 MHz phase generator
  // ----------------------------------------------------------------
  // 4 MHz tick from a divider, then toggled into two antiphase 2 MHz phases
  logic [$clog2(HALF_DIV)-1:0] div_ff;
  logic                        two_megahertz_clock_ff;
  logic                        src_tick;
  logic                        rise_2m;
  logic                        fall_2m;

  assign src_tick = (div_ff == ($clog2(HALF_DIV))'(HALF_DIV - 1));
  assign rise_2m  = src_tick && !two_megahertz_clock_ff;
  assign fall_2m  = src_tick && two_megahertz_clock_ff;

  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      div_ff                 <= '0;
      two_megahertz_clock_ff <= 1'b0;
    end else begin
      div_ff <= src_tick ? '0 : div_ff + 1'b1;
      if (src_tick) begin
        two_megahertz_clock_ff <= !two_megahertz_clock_ff;
      end
    end
  end

  // ----------------------------------------------------------------
  // Host write decode
  // ----------------------------------------------------------------
  logic wr_prev_ff;
  logic wr_active;
  logic wr_release;

  // Interface select gates every host access
  assign wr_active  = !host_ff.wr_n && !host_ff.sel_n;
  assign wr_release = !wr_prev_ff && host_ff.wr_n;

  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      wr_prev_ff <= 1'b1;
    end else begin
      wr_prev_ff <= !wr_active;
    end
  end

  logic [BYTE_W-1:0] target_address_latch_ff;
  logic              addr_kind_ff;

  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      target_address_latch_ff <= ADDR_RESET;
      addr_kind_ff            <= 1'b0;
    end else begin
      if (wr_active) begin
        addr_kind_ff <= host_ff.kind;
      end
      // Captured on strobe rise, using the kind seen during the pulse
      if (wr_release && addr_kind_ff == BYTE_KIND_ADDR) begin
        target_address_latch_ff <= host_ff.data;
      end
    end
  end

  // ----------------------------------------------------------------
  // Sequencer and shifter
  // ----------------------------------------------------------------
  lcscb_state_e      state_ff;
  logic [3:0]        bit_cnt_ff;
  logic [BYTE_W-1:0] control_data_shifter_ff;
  logic              select_n_ff;
  logic              out_bit_ff;
  logic              retimed_ff;

  // Down-counter one-shot; a data write mid-transfer is ignored, only LCSCB_IDLE accepts one
  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      state_ff                <= LCSCB_IDLE;
      bit_cnt_ff              <= '0;
      control_data_shifter_ff <= SHIFT_RESET;
      select_n_ff             <= 1'b1;
      out_bit_ff              <= 1'b1;
    end else begin
      case (state_ff)
        LCSCB_IDLE: begin
          if (wr_active && host_ff.kind == BYTE_KIND_DATA) begin
            state_ff <= LCSCB_LOAD;
          end
        end
        LCSCB_LOAD: begin
          if (rise_2m && wr_active) begin
            control_data_shifter_ff <= host_ff.data;
          end
          if (wr_release) begin
            state_ff <= LCSCB_ARM;
          end
        end
        LCSCB_ARM: begin
          if (rise_2m) begin
            select_n_ff <= 1'b0;
            out_bit_ff  <= control_data_shifter_ff[0];
            bit_cnt_ff  <= 4'(BITS_PER_XFER);
            state_ff    <= LCSCB_SHIFT;
          end
        end
        LCSCB_SHIFT: begin
          if (rise_2m) begin
            // Shift right: send LSB first, retimed reply enters at MSB
            control_data_shifter_ff <= {retimed_ff, control_data_shifter_ff[BYTE_W-1:1]};
            bit_cnt_ff              <= bit_cnt_ff - 4'h1;
            if (bit_cnt_ff == 4'h1) begin
              select_n_ff <= 1'b1;
              out_bit_ff  <= 1'b1;
              state_ff    <= LCSCB_IDLE;
            end else begin
              out_bit_ff <= control_data_shifter_ff[1];
            end
          end
        end
        default: state_ff <= LCSCB_IDLE;
      endcase
    end
  end

  // Reply sampled on the inverted phase, mid bit
  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      retimed_ff <= 1'b1;
    end else if (fall_2m && state_ff == LCSCB_SHIFT) begin
      retimed_ff <= ser_sync_ff;
    end
  end

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  function automatic logic [BYTE_W-1:0] gate_address(input logic [BYTE_W-1:0] addr,
                                                     input logic              mode_n,
                                                     input logic              sel_n);
    if (mode_n) begin
      gate_address = addr | {BYTE_W{sel_n}};
    end else begin
      gate_address = addr;
    end
  endfunction : gate_address

  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I) begin
      HOST_DATA_BUS_O          <= '0;
      HOST_DATA_BUS_OE_O       <= 1'b0;
      SERIAL_CONTROL_LINE_O    <= 1'b0;
      SERIAL_CONTROL_LINE_OE_O <= 1'b0;
      TARGET_SELECT_PULSE_N_O  <= 1'b1;
      SERIAL_CONTROL_CLOCK_O   <= 1'b0;
      TARGET_ADDRESS_OUTPUTS_O <= {BYTE_W{1'b1}};
    end else begin
      HOST_DATA_BUS_O          <= control_data_shifter_ff;
      HOST_DATA_BUS_OE_O       <= !host_ff.rd_n && !host_ff.sel_n;
      // Open drain: only a zero is driven, ones are released to the pull-up
      SERIAL_CONTROL_LINE_O    <= 1'b0;
      SERIAL_CONTROL_LINE_OE_O <= !select_n_ff && !out_bit_ff;
      TARGET_SELECT_PULSE_N_O  <= select_n_ff;
      SERIAL_CONTROL_CLOCK_O   <= two_megahertz_clock_ff;
      TARGET_ADDRESS_OUTPUTS_O <= gate_address(target_address_latch_ff, mode_sync_ff, select_n_ff);
    end
  end

endmodule : lcscb_bridge

/* File: src/lcscb_pkg.sv */
// Constants and carrier types for the line card serial control bridge.
// Assumes a single 200 MHz core clock; host strobes arrive asynchronously.
//
// Summary of operation
// - Write with byte kind low captures host byte as target address on strobe rise.
// - Write with byte kind high loads shifter on a 2 MHz rising edge during strobe.
// - Strobe return after a data write starts sending the byte to selected slaves.
// - Read strobe low drives shifter onto host bus; otherwise bus pins are inputs.
// - Interface select high makes the bridge ignore host reads and writes.
// - Serial data and select activate only after data write; counter runs one-shot.
// - Incoming serial bits are retimed on inverted 2 MHz and shifted in.
// - Mode high: select pulse gates address outputs whose latched bit is zero.
// - Mode low: latched address drives outputs continuously for external decode.
// - Serial line and serial clock are shared by all slaves in both modes.
// - Port gives bidirectional serial line, active-low select and serial clock.
// - Logic runs on antiphase 2 MHz phases derived from a 4 MHz source.
package lcscb_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CORE_CLK_HZ      = 200_000_000;
  localparam int unsigned SOURCE_CLK_HZ    = 4_000_000;
  localparam int unsigned HALF_DIV         = CORE_CLK_HZ / SOURCE_CLK_HZ;
  localparam int unsigned BITS_PER_XFER    = 8;

  // ----------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------
  localparam int unsigned BYTE_W           = 8;
  localparam logic [7:0]  ADDR_RESET       = 8'hff;
  localparam logic [7:0]  SHIFT_RESET      = 8'hff;
  localparam logic        BYTE_KIND_ADDR   = 1'b0;
  localparam logic        BYTE_KIND_DATA   = 1'b1;

  typedef enum logic [1:0] {
    LCSCB_IDLE,
    LCSCB_LOAD,
    LCSCB_ARM,
    LCSCB_SHIFT
  } lcscb_state_e;

  // Host side strobes after synchronising
  typedef struct packed {
    logic       wr_n;
    logic       rd_n;
    logic       sel_n;
    logic       kind;
    logic [7:0] data;
  } lcscb_host_s;

endpackage : lcscb_pkg

/* File: verification/lcscb_bridge_checker.sv */
// Checker for host bus, select window and serial port.
// Assumes the 200 MHz core clock and sync reset.
`timescale 1ns/1ps
module lcscb_bridge_checker (
  input wire logic       CORE_CLK_I,
  input wire logic       RESET_I,
  input wire logic       RD_N_I,
  input wire logic       IF_SELECT_N_I,
  input wire logic       ADDRESSING_MODE_N_I,
  input wire logic       HOST_DATA_BUS_OE_O,
  input wire logic       SERIAL_CONTROL_LINE_O,
  input wire logic       SERIAL_CONTROL_LINE_OE_O,
  input wire logic       TARGET_SELECT_PULSE_N_O,
  input wire logic       SERIAL_CONTROL_CLOCK_O,
  input wire logic [7:0] TARGET_ADDRESS_OUTPUTS_O
);
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (RESET_I);
  int low_cnt;
  always_ff @(posedge CORE_CLK_I) begin
    if (RESET_I || TARGET_SELECT_PULSE_N_O) low_cnt <= 0;
    else low_cnt <= low_cnt + 1;
  end
  sequence rd_held; (!RD_N_I && !IF_SELECT_N_I) [*4]; endsequence
  sequence idle_held; (RD_N_I || IF_SELECT_N_I) [*4]; endsequence
  read_drive_a: assert property (rd_held |=> HOST_DATA_BUS_OE_O)
    else $error("bus not driven on read");
  bus_release_a: assert property (idle_held |=> !HOST_DATA_BUS_OE_O)
    else $error("bus driven outside read");
  sel_ignore_a: assert property (IF_SELECT_N_I [*4] |=> !HOST_DATA_BUS_OE_O)
    else $error("read taken while deselected");
  line_idle_a: assert property (TARGET_SELECT_PULSE_N_O && $past(TARGET_SELECT_PULSE_N_O)
    |-> !SERIAL_CONTROL_LINE_OE_O)
    else $error("line driven outside select");
  open_drain_a: assert property (1'b1 |-> !SERIAL_CONTROL_LINE_O)
    else $error("line driven high");
  sel_len_a: assert property ($rose(TARGET_SELECT_PULSE_N_O) |-> low_cnt == 800)
    else $error("select window not eight bits");
  gate_idle_a: assert property (ADDRESSING_MODE_N_I && $past(ADDRESSING_MODE_N_I, 3) && TARGET_SELECT_PULSE_N_O
    && $past(TARGET_SELECT_PULSE_N_O) |-> TARGET_ADDRESS_OUTPUTS_O == 8'hff)
    else $error("gated address low outside select");
  decode_hold_a: assert property (!ADDRESSING_MODE_N_I && !$past(ADDRESSING_MODE_N_I, 4)
    && $fell(TARGET_SELECT_PULSE_N_O) |-> $stable(TARGET_ADDRESS_OUTPUTS_O) [*8])
    else $error("decode address moved with select");
  sclk_half_a: assert property ($changed(SERIAL_CONTROL_CLOCK_O) |=> $stable(SERIAL_CONTROL_CLOCK_O) [*8])
    else $error("serial clock too fast");
endmodule : lcscb_bridge_checker
bind lcscb_bridge lcscb_bridge_checker lcscb_bridge_checker_i (.CORE_CLK_I, .RESET_I, .RD_N_I, .IF_SELECT_N_I,
  .ADDRESSING_MODE_N_I, .HOST_DATA_BUS_OE_O, .SERIAL_CONTROL_LINE_O, .SERIAL_CONTROL_LINE_OE_O,
  .TARGET_SELECT_PULSE_N_O, .SERIAL_CONTROL_CLOCK_O, .TARGET_ADDRESS_OUTPUTS_O);

/* File: verification/lcscb_slave_model.sv */
// Slave serial port model: open-drain reply, LSB first.
// Assumes the bench pulls the shared line up.
`timescale 1ns/1ps
module lcscb_slave_model (
  input  wire logic       sclk_i,
  input  wire logic       sel_n_i,
  input  wire logic [7:0] reply_i,
  output logic            oe_o
);
  int idx = 8;
  always @(negedge sel_n_i) idx = 0;
  // Advance after the bridge has sampled
  always @(negedge sclk_i) if (!sel_n_i) idx = idx + 1;
  assign oe_o = !sel_n_i && idx < 8 && !reply_i[idx[2:0]];
endmodule : lcscb_slave_model

/* File: verification/test_line_card_serial_control_bridge.sv */
// Testbench: host byte writes and reads against one slave model.
// Assumes the bridge and slave model compiled before it.
`timescale 1ns/1ps
module test_line_card_serial_control_bridge;
  logic clk = 0, rst = 1, wr_n = 1, rd_n = 1, cs_n = 0, kind = 0, mode_n = 1;
  logic [7:0] din = 8'h00, reply = 8'h3c, dout, addr;
  logic doe, lo, loe, sel_n, sclk, soe;
  wire line = !(loe || soe);
  // Gated mode: slave select on address output 0; decode mode: card f, slot 6
  wire slave_cs_n = mode_n ? addr[0] : (sel_n || addr[6:3] != 4'hf || addr[2:0] != 3'h6);
  int fail_count = 0, n_tests = 0;
  always #2.5 clk = ~clk;
  lcscb_bridge lcscb_bridge_i (.CORE_CLK_I(clk), .RESET_I(rst), .WR_N_I(wr_n), .RD_N_I(rd_n),
    .IF_SELECT_N_I(cs_n), .BYTE_KIND_SELECT_I(kind), .HOST_DATA_BUS_I(din), .HOST_DATA_BUS_O(dout),
    .HOST_DATA_BUS_OE_O(doe), .ADDRESSING_MODE_N_I(mode_n), .SERIAL_CONTROL_LINE_I(line),
    .SERIAL_CONTROL_LINE_O(lo), .SERIAL_CONTROL_LINE_OE_O(loe), .TARGET_SELECT_PULSE_N_O(sel_n),
    .SERIAL_CONTROL_CLOCK_O(sclk), .TARGET_ADDRESS_OUTPUTS_O(addr));
  lcscb_slave_model lcscb_slave_model_i (.sclk_i(sclk), .sel_n_i(slave_cs_n), .reply_i(reply), .oe_o(soe));
  task automatic finish_test;
    if (fail_count == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : finish_test
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask : cyc
  // Strobe held 600 ns so a 2 MHz rise lands inside
  task automatic wr(input logic k, input logic [7:0] d);
    kind = k;
    din = d;
    wr_n = 0;
    cyc(120);
    wr_n = 1;
    cyc(10);
  endtask : wr
  task automatic wait_sel(input logic lvl);
    int i;
    i = 0;
    while (sel_n !== lvl && i < 2000) begin
      cyc(1);
      i++;
    end
    if (sel_n !== lvl) begin
      fail_count++;
      $display("Error %0t: select did not reach %b", $time, lvl);
      finish_test();
    end else begin
      cyc(3);
    end
  endtask : wait_sel
  task automatic rd(input logic [7:0] exp, input logic en);
    rd_n = 0;
    cyc(6);
    if (en) check(dout, exp);
    check({7'h00, doe}, {7'h00, en});
    rd_n = 1;
    cyc(6);
  endtask : rd
  initial begin
    cyc(12);
    rst = 0;
    cyc(4);
    check(addr, 8'hff);
    rd(8'hff, 1);
    wr(0, 8'hfe);
    check(addr, 8'hff);
    wr(1, 8'h5a);
    wait_sel(0);
    check(addr, 8'hfe);
    wait_sel(1);
    rd(8'h5a & reply, 1);
    cyc(1600);
    wr(1, 8'hff);
    wait_sel(0);
    wait_sel(1);
    rd(reply, 1);
    cs_n = 1;
    wr(0, 8'h00);
    rd(8'h00, 0);
    cs_n = 0;
    wr(0, 8'h00);
    cyc(1600);
    wr(1, 8'hc3);
    wait_sel(0);
    check(addr, 8'h00);
    wait_sel(1);
    rd(8'hc3 & reply, 1);
    wr(0, 8'hfe);
    mode_n = 0;
    cyc(4);
    check(addr, 8'hfe);
    cyc(1600);
    wr(1, 8'h81);
    wait_sel(0);
    check(addr, 8'hfe);
    wait_sel(1);
    rd(8'h81 & reply, 1);
    cyc(1600);
    wr(0, 8'h7d);
    wr(1, 8'hff);
    wait_sel(0);
    wait_sel(1);
    rd(8'hff, 1);
    finish_test();
  end
endmodule : test_line_card_serial_control_bridge
